// [design/ltp_pattern_test.sv]
// link test pattern engine with apb registers and output fifo
// assumes the lane serialiser consumes one 16-bit symbol word per txReady
`timescale 1ns/1ps

module ltp_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             count;
    } ltp_fifo_t;
    ltp_fifo_t st;
    ltp_fifo_t next_st;
    logic      doPush;
    logic      doPop;

    assign inReady  = st.count != FULL;
    assign outValid = st.count != '0;
    assign outData  = st.mem[st.rp];

    always_comb begin
        next_st = st;
        doPush  = inValid && inReady;
        doPop   = outValid && outReady;
        if (doPush) begin
            next_st.mem[st.wp] = inData;
            next_st.wp = st.wp + 1'b1;
        end
        if (doPop) begin
            next_st.rp = st.rp + 1'b1;
        end
        if (doPush && !doPop) begin
            next_st.count = st.count + 1'b1;
        end else if (doPop && !doPush) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ltp_fifo

module ltp_pattern_test (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        globalStart,
    input  wire logic        txReady,
    output logic             txValid,
    output logic [15:0]      txWord,
    output logic             testRunning
);
    typedef struct packed {
        logic [7:0]          ctrl;
        logic [31:0]         symBuf;
        logic [31:0]         ext;
        logic [3:0]          typeSel;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        ltp_pkg::ltp_state_t state;
        logic [2:0]          symIdx;
        logic [11:0]         setCnt;
        logic [2:0]          lane;
        logic                firstSym;
        logic                outValid;
        logic [15:0]         outWord;
        logic                running;
    } ltp_top_t;
    ltp_top_t    st;
    ltp_top_t    next_st;
    logic        start;
    logic        pushValid;
    logic [15:0] pushWord;
    logic        pushReady;
    logic        fifoValid;
    logic [15:0] fifoData;
    logic        fifoTake;
    logic [1:0]  grp;
    logic [11:0] skipInt;
    logic        skipDue;
    logic        access;
    logic        mapped;

    assign grp     = st.ext[ltp_pkg::EXT_GRP_LSB +: 2];
    assign skipInt = st.ext[ltp_pkg::EXT_SKIP_LSB +: 12];
    assign start   = st.ctrl[ltp_pkg::CTRL_START] | globalStart;
    assign skipDue = !st.ctrl[ltp_pkg::CTRL_SKIP_SUP] && skipInt != '0
                     && (st.setCnt + 12'h001) == skipInt;
    assign access  = psel && penable && st.pready;
    assign mapped  = paddr == ltp_pkg::ADDR_CTRL || paddr == ltp_pkg::ADDR_SYMBUF
                     || paddr == ltp_pkg::ADDR_EXT || paddr == ltp_pkg::ADDR_TYPE;
    assign fifoTake = !st.outValid || txReady;

    ltp_fifo #(
        .W     (ltp_pkg::WORD_W),
        .DEPTH (ltp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .inValid  (pushValid),
        .inData   (pushWord),
        .inReady  (pushReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (fifoTake)
    );

    always_comb begin
        next_st   = st;
        pushValid = 1'b0;
        pushWord  = '0;
        // apb: answer one cycle into access phase
        next_st.pready  = psel && penable && !st.pready;
        next_st.pslverr = psel && penable && !st.pready && !mapped;
        next_st.prdata  = '0;
        if (psel && penable && !st.pready && !pwrite) begin
            unique case (paddr)
                ltp_pkg::ADDR_CTRL:   next_st.prdata = {24'h000000, st.ctrl};
                ltp_pkg::ADDR_SYMBUF: next_st.prdata = st.symBuf;
                ltp_pkg::ADDR_EXT:    next_st.prdata = st.ext;
                ltp_pkg::ADDR_TYPE:   next_st.prdata = {st.typeSel, 28'h0000000};
                default:              next_st.prdata = '0;
            endcase
        end
        if (access && pwrite) begin
            unique case (paddr)
                ltp_pkg::ADDR_CTRL:   next_st.ctrl = pwdata[7:0] & ltp_pkg::CTRL_WMASK;
                ltp_pkg::ADDR_SYMBUF: next_st.symBuf = pwdata;
                ltp_pkg::ADDR_EXT:    next_st.ext = pwdata & ltp_pkg::EXT_WMASK;
                ltp_pkg::ADDR_TYPE:   next_st.typeSel = pwdata[ltp_pkg::TYPE_LSB +: 4];
                default:              next_st.ctrl = st.ctrl;
            endcase
        end
        pushWord[7:0] = st.symBuf[{st.symIdx[1:0], 3'b000} +: 8];
        pushWord[ltp_pkg::W_CTRL] = st.typeSel[st.symIdx[1:0]];
        pushWord[ltp_pkg::W_FDISP] = st.firstSym;
        pushWord[ltp_pkg::W_DISPV] = st.firstSym && st.ctrl[ltp_pkg::CTRL_DISP];
        // delay only for groups of four or eight
        pushWord[ltp_pkg::W_DLYEN] = grp == ltp_pkg::GRP_FOUR || grp == ltp_pkg::GRP_EIGHT;
        pushWord[ltp_pkg::W_LANE_LSB +: 3] = st.ctrl[ltp_pkg::CTRL_AUTO]
                                             ? st.lane : st.ctrl[ltp_pkg::CTRL_LANE_LSB +: 3];
        unique case (st.state)
            ltp_pkg::ST_IDLE: begin
                if (start) begin
                    next_st.state    = ltp_pkg::ST_SEND;
                    next_st.symIdx   = '0;
                    next_st.setCnt   = '0;
                    next_st.firstSym = 1'b1;
                    next_st.lane     = st.ctrl[ltp_pkg::CTRL_LANE_LSB +: 3];
                end
            end
            ltp_pkg::ST_SEND: begin
                if (!start) begin
                    next_st.state = ltp_pkg::ST_IDLE;
                end else begin
                    pushValid = 1'b1;
                    if (pushReady) begin
                        next_st.firstSym = 1'b0;
                        next_st.symIdx   = st.symIdx + 3'h1;
                        if (st.symIdx == ltp_pkg::SET_LAST) begin
                            if (st.ctrl[ltp_pkg::CTRL_AUTO] && grp == ltp_pkg::GRP_FOUR) begin
                                next_st.lane = {st.lane[2], st.lane[1:0] + 2'h1};
                            end else if (st.ctrl[ltp_pkg::CTRL_AUTO] && grp == ltp_pkg::GRP_EIGHT) begin
                                next_st.lane = st.lane + 3'h1;
                            end
                            if (skipDue) begin
                                next_st.setCnt = '0;
                                next_st.state  = ltp_pkg::ST_SKIP;
                            end else begin
                                next_st.setCnt = st.setCnt + 12'h001;
                            end
                        end
                    end
                end
            end
            ltp_pkg::ST_SKIP: begin
                if (!start) begin
                    next_st.state = ltp_pkg::ST_IDLE;
                end else begin
                    pushValid = 1'b1;
                    pushWord  = '0;
                    pushWord[7:0] = ltp_pkg::SKIP_SYM;
                    pushWord[ltp_pkg::W_CTRL] = 1'b1;
                    pushWord[ltp_pkg::W_SKIP] = 1'b1;
                    if (pushReady) begin
                        next_st.state = ltp_pkg::ST_SEND;
                    end
                end
            end
        endcase
        next_st.running = next_st.state != ltp_pkg::ST_IDLE;
        if (fifoTake) begin
            next_st.outValid = fifoValid;
            next_st.outWord  = fifoData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.state   <= ltp_pkg::ST_IDLE;
            st.ctrl    <= ltp_pkg::CTRL_RESET;
            st.symBuf  <= ltp_pkg::SYMBUF_RESET;
            st.ext     <= ltp_pkg::EXT_RESET;
            st.typeSel <= ltp_pkg::TYPE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata      = st.prdata;
    assign pready      = st.pready;
    assign pslverr     = st.pslverr;
    assign txValid     = st.outValid;
    assign txWord      = st.outWord;
    assign testRunning = st.running;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ctrl_rsvd_zero: assert property (!st.ctrl[ltp_pkg::CTRL_RSVD])
        else $error("reserved control bit set");
    a_skip_blocked: assert property (st.ctrl[ltp_pkg::CTRL_SKIP_SUP] |->
        !(pushValid && pushWord[ltp_pkg::W_SKIP]))
        else $error("skip sent while suppressed");
    a_first_disp: assert property (pushValid && pushWord[ltp_pkg::W_FDISP] |->
        st.symIdx == 3'h0 && pushWord[ltp_pkg::W_DISPV] == st.ctrl[ltp_pkg::CTRL_DISP])
        else $error("first symbol disparity wrong");
    a_start_run: assert property (start && st.state == ltp_pkg::ST_IDLE |=>
        st.state == ltp_pkg::ST_SEND && testRunning)
        else $error("engine did not start");
    a_stop_idle: assert property (!start |=> st.state == ltp_pkg::ST_IDLE)
        else $error("engine did not stop");
    a_skip_enter: assert property (st.state == ltp_pkg::ST_SEND && start && pushReady
        && st.symIdx == ltp_pkg::SET_LAST && skipDue |=> st.state == ltp_pkg::ST_SKIP && st.setCnt == 12'h000)
        else $error("skip set missed");
    a_skip_zero: assert property (st.state == ltp_pkg::ST_SEND && skipInt == 12'h000 |=>
        st.state != ltp_pkg::ST_SKIP)
        else $error("skip with zero interval");
    a_lane_fixed: assert property (st.state == ltp_pkg::ST_SEND && pushValid && !st.ctrl[ltp_pkg::CTRL_AUTO] |->
        pushWord[ltp_pkg::W_LANE_LSB +: 3] == st.ctrl[ltp_pkg::CTRL_LANE_LSB +: 3])
        else $error("fixed lane moved");
    a_lane_group4: assert property (st.state == ltp_pkg::ST_SEND && grp == ltp_pkg::GRP_FOUR
        && $stable(st.lane[2]) ##1 st.lane != $past(st.lane) |-> st.lane[2] == $past(st.lane[2]))
        else $error("lane left its group of four");
    a_no_delay: assert property (pushValid && grp != ltp_pkg::GRP_FOUR
        && grp != ltp_pkg::GRP_EIGHT |-> !pushWord[ltp_pkg::W_DLYEN])
        else $error("delay symbol with no group");
    a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing");

    c_run_start: cover property (st.state == ltp_pkg::ST_IDLE ##1 st.state == ltp_pkg::ST_SEND);
    c_skip_sent: cover property (pushValid && pushReady && pushWord[ltp_pkg::W_SKIP]);
    c_fifo_full: cover property (pushValid && !pushReady);
    c_reg_write: cover property (access && pwrite && paddr == ltp_pkg::ADDR_CTRL);
endmodule : ltp_pattern_test

// [inc/ltp_pkg.sv]
// constants and types for the link pattern test control block
// assumes a 32-bit apb slave with 12-bit byte addresses
package ltp_pkg;
    localparam logic [11:0] ADDR_CTRL     = 12'h380;
    localparam logic [11:0] ADDR_SYMBUF   = 12'h384;
    localparam logic [11:0] ADDR_EXT      = 12'h388;
    localparam logic [11:0] ADDR_TYPE     = 12'h390;
    localparam logic [7:0]  CTRL_RESET    = 8'h08;
    localparam logic [7:0]  CTRL_WMASK    = 8'hfb;
    localparam logic [31:0] SYMBUF_RESET  = 32'h4abcb5bc;
    localparam logic [31:0] EXT_RESET     = 32'h04000000;
    localparam logic [31:0] EXT_WMASK     = 32'h0cfff000;
    localparam logic [3:0]  TYPE_RESET    = 4'h5;
    localparam int          CTRL_SKIP_SUP = 7;
    localparam int          CTRL_LANE_LSB = 4;
    localparam int          CTRL_AUTO     = 3;
    localparam int          CTRL_RSVD     = 2;
    localparam int          CTRL_DISP     = 1;
    localparam int          CTRL_START    = 0;
    localparam int          EXT_GRP_LSB   = 26;
    localparam int          EXT_SKIP_LSB  = 12;
    localparam int          TYPE_LSB      = 28;
    localparam int          WORD_W        = 16;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          W_CTRL        = 8;
    localparam int          W_SKIP        = 9;
    localparam int          W_FDISP       = 10;
    localparam int          W_DISPV       = 11;
    localparam int          W_DLYEN       = 12;
    localparam int          W_LANE_LSB    = 13;
    localparam logic [1:0]  GRP_NONE      = 2'h0;
    localparam logic [1:0]  GRP_FOUR      = 2'h1;
    localparam logic [1:0]  GRP_EIGHT     = 2'h2;
    localparam logic [2:0]  SET_LAST      = 3'h7;
    localparam logic [7:0]  SKIP_SYM      = 8'h1c;
    typedef enum {ST_IDLE, ST_SEND, ST_SKIP} ltp_state_t;
endpackage : ltp_pkg

// [sim/ltp_link_sink.sv]
// link partner model: takes test words and paces or stalls their acceptance
// assumes txValid and txWord stand until taken, as the engine's handshake says
`timescale 1ns/1ps

module ltp_link_sink (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic hold,
    output logic      txReady
);
    logic [1:0] pace;

    // ready every cycle, or one cycle in four when slow; held low while hold is set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pace    <= 2'h0;
            txReady <= 1'b0;
        end else begin
            pace    <= pace + 2'h1;
            txReady <= !hold && (!slow || pace == 2'h3);
        end
    end
endmodule : ltp_link_sink

// [sim/ltp_pattern_test_tb_top.sv]
// self-checking bench for the link pattern test engine
// assumes apb slave answers in its own time and a partner that paces txReady
`timescale 1ns/1ps

module ltp_pattern_test_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        globalStart = 1'b0;
    logic        txReady;
    logic        txValid;
    logic [15:0] txWord;
    logic        testRunning;
    logic        slow = 1'b0;
    logic        hold = 1'b0;
    int          mismatches = 0;
    int          n_checks = 0;
    logic [15:0] got [$];
    localparam logic [31:0] SYMS = 32'hbc4a1cb5;
    localparam logic [3:0]  TYPS = 4'ha;
    localparam logic [11:0] R_ADDR [5] = '{12'h380, 12'h384, 12'h388, 12'h390, 12'h38c};
    localparam logic [31:0] R_WR   [5] = '{32'hf6, 32'h12345678, 32'hffffffff, 32'hffffffff, 32'hffffffff};
    localparam logic [31:0] R_EXP  [5] = '{32'hf2, 32'h12345678, 32'h0cfff000, 32'hf0000000, 32'h0};
    localparam logic [4:0]  R_ERR  = 5'b10000;

    always #2.5 sys_clk = ~sys_clk;

    ltp_pattern_test i_ltp_pattern_test (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .globalStart(globalStart), .txReady(txReady), .txValid(txValid), .txWord(txWord),
        .testRunning(testRunning));
    ltp_link_sink i_ltp_link_sink (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .hold(hold), .txReady(txReady));

    always @(posedge sys_clk) if (txValid === 1'b1 && txReady === 1'b1) got.push_back(txWord);

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) mismatches++;
    endtask : apb

    task automatic apb_wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, wd, r, e);
    endtask : apb_wr

    task automatic run_test(input logic [7:0] ctrl, input logic [1:0] grp, input logic [11:0] ival,
                            input logic useGlobal, input logic [1:0] mode);
        int          n;
        int          k;
        int          cnt;
        int          j;
        logic [2:0]  lane;
        logic        dly;
        logic [15:0] ew;
        logic [15:0] mk;
        apb_wr(12'h388, {4'h0, grp, 2'h0, ival, 12'h000});
        got.delete();
        slow <= mode[0];
        hold <= mode[1];
        // either start source runs the engine; control fields load in both cases
        apb_wr(12'h380, {24'h0, ctrl | {7'h00, !useGlobal}});
        if (useGlobal) globalStart <= 1'b1;
        if (mode[1]) begin
            repeat (40) @(posedge sys_clk);
            check("running while stalled", 1, testRunning);
            check("nothing taken while stalled", 0, got.size());
            hold <= 1'b0;
        end
        n = 0;
        while (got.size() < 24 && n < 3000) begin @(posedge sys_clk); n++; end
        globalStart <= 1'b0;
        apb_wr(12'h380, {24'h0, ctrl});
        n = 0;
        while (testRunning !== 1'b0 && n < 20) begin @(posedge sys_clk); n++; end
        check("stopped", 0, testRunning);
        n = 0;
        while (txValid !== 1'b0 && n < 200) begin @(posedge sys_clk); n++; end
        lane = ctrl[6:4];
        dly = (grp == 2'h1 || grp == 2'h2);
        cnt = 0;
        k = 0;
        while (k < 24) begin
            // symbol order, type, disparity, delay lane
            for (j = 0; j < 8 && k < 24; j++) begin
                ew = {lane, dly, (k == 0) ? ctrl[1] : 1'b0, k == 0, 1'b0, TYPS[j % 4], SYMS[8 * (j % 4) +: 8]};
                mk = 16'h17ff | (dly ? 16'he000 : 16'h0) | ((k == 0) ? 16'h0800 : 16'h0);
                check("pattern word", {16'h0, ew & mk}, {16'h0, got[k] & mk});
                k++;
            end
            // auto step wraps within the lane group
            if (ctrl[3]) lane = (grp == 2'h1) ? {lane[2], lane[1:0] + 2'h1} : lane + 3'h1;
            cnt++;
            // skip after programmed sets unless suppressed or zero
            if (!ctrl[7] && ival != 0 && cnt == ival && k < 24) begin
                check("skip word", 32'h031c, {16'h0, got[k] & 16'h07ff});
                k++;
                cnt = 0;
            end
        end
    endtask : run_test

    initial begin
        logic [31:0] rd;
        logic        er;
        logic [31:0] resv [4];
        resv = '{{24'h0, ltp_pkg::CTRL_RESET}, ltp_pkg::SYMBUF_RESET, ltp_pkg::EXT_RESET,
                 {ltp_pkg::TYPE_RESET, 28'h0}};
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        // read back, reserved bits and unmapped place
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, R_ADDR[i], R_WR[i], rd, er);
            check("write error", R_ERR[i], er);
            apb(1'b0, R_ADDR[i], 32'h0, rd, er);
            check("read back", R_EXP[i], rd);
            check("read error", R_ERR[i], er);
        end
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        check("idle after reset", 0, {txValid, testRunning});
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, R_ADDR[i], 32'h0, rd, er);
            check("reset value", resv[i], rd);
        end
        apb_wr(12'h384, SYMS);
        apb_wr(12'h390, {TYPS, 28'h0});
        run_test(8'h52, 2'h2, 12'h002, 1'b1, 2'h0);
        run_test(8'he8, 2'h1, 12'h001, 1'b0, 2'h1);
        run_test(8'h78, 2'h2, 12'h000, 1'b0, 2'h2);
        run_test(8'h00, 2'h0, 12'h001, 1'b0, 2'h0);
        print_verdict();
    end

    initial begin
        #200us;
        mismatches++;
        print_verdict();
    end
endmodule : ltp_pattern_test_tb_top
